// file: rtl/pin_error_params.svh
// Purpose: Offsets, field positions and reset values of the pin and error status bank.
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus.
// Notes: Definitions only.
`ifndef PIN_ERROR_PARAMS_SVH
`define PIN_ERROR_PARAMS_SVH
// The two status registers sit at word indices; the byte address is four times the index.
`define IDX_SETUP_PIN_LEVELS 6'h34
`define IDX_ERROR_CAUSE_INFO 6'h3a
`define OFF_IRQ_STATUS 8'h40
`define OFF_IRQ_MASK 8'h44
`define OFF_CLEAR_CTRL 8'h48
`define RECONFIG_LSB 12
`define FIX_LSB 8
`define RX_CAUSE_LSB 5
`define SOURCE_ID_LSB 0
`define ERROR_CAUSE_RESET 16'h0000
`define RX_CAUSE_MULTI 3'h7
`define RX_CAUSE_LENGTH 3'h3
`define RX_CAUSE_FIXSTOP 3'h5
`define RX_CAUSE_PAGE 3'h6
`define RECONFIG_NOISE 3'h0
`define IRQ_RESET 3'h0
`endif

// file: rtl/pin_error_pkg.sv
// Purpose: Types shared by the pin and error status bank.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Constants live in the params header.
package pin_error_pkg;
    typedef logic [2:0] cause_t;
    typedef logic [4:0] source_id_t;
    typedef logic [15:0] reg16_t;
endpackage : pin_error_pkg

// file: rtl/pin_and_error_status_regs.sv
// Purpose: Setup pin mirror and error cause registers behind an AXI4-Lite slave.
// Assumes: Pins are asynchronous; error events come from logic on aclk.
// Notes: One write and one read under way at most.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`include "pin_error_params.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Bits 15..9 mirror seven setup pins.
// - Bits 5..0 mirror six further setup pins.
// - Swap and width also appear at 7,6.
// - Bit 8 set when any test pin low.
// - One other setup pin, tolerance, is not shown.
// - Error register read-only with fixed field layout.
// - Reconfig cause cleared by clear-flags or reset.
// - Reconfig cause codes 000 to 101 recorded.
// - Tolerance pin low allows only cause 000.
// - Fix info top bit gives port, hub-gated.
// - Fix info cleared by flag write-one or reset.
// - Low fix bits encode state and substitution.
// - Receive error cause cleared by flag write-one.
// - Receive error codes 000 to 110 recorded.
// - Concurrent length/stop/page errors give 111.
// - Failing source ID captured, cleared alike.
module pin_and_error_status_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic byte_swap_pin,
    input wire logic word_width_pin,
    input wire logic operating_mode_pin,
    input wire logic hub_enable_pin,
    input wire logic ext_hub_write_pin,
    input wire logic ext_hub_read_pin,
    input wire logic code_bypass_pin,
    input wire logic diagnostic_pin,
    input wire logic tx_enable_polarity_pin,
    input wire logic time_prescale_b1,
    input wire logic time_prescale_b0,
    input wire logic warn_prescale_b1,
    input wire logic warn_prescale_b0,
    input wire logic [3:0] factory_test_pins,
    input wire logic test_mode_pin,
    input wire logic ack_tolerance_pin,
    input wire logic soft_reset,
    input wire logic clear_flags_cmd,
    input wire logic reconfig_event,
    input wire pin_error_pkg::cause_t reconfig_code,
    input wire logic line_fix_event,
    input wire logic line_fix_port2,
    input wire pin_error_pkg::cause_t line_fix_code,
    input wire logic line_fix_flag_clear,
    input wire logic rx_error_event,
    input wire pin_error_pkg::cause_t rx_error_code,
    input wire logic rx_err_length,
    input wire logic rx_err_fixstop,
    input wire logic rx_err_page,
    input wire pin_error_pkg::source_id_t rx_error_sid,
    input wire logic rx_error_flag_clear,
    output logic irq
);
    import pin_error_pkg::*;

    localparam int NPIN = 19;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts when stages two and three agree.
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] sync3;
    logic [NPIN-1:0] pin_q;

    // Bit positions of pin_raw, kept by every stage behind it:
    //   bit 18 is the byte swap pin;
    //   bit 17 is the word width pin;
    //   bit 16 is the operating mode pin;
    //   bit 15 is the hub enable pin;
    //   bit 14 is the external hub write pin;
    //   bit 13 is the external hub read pin;
    //   bit 12 is the code bypass pin;
    //   bit 11 is the diagnostic pin;
    //   bit 10 is the transmit-enable polarity pin;
    //   bits 9 and 8 are time prescaler bits 1 and 0;
    //   bits 7 and 6 are warning prescaler bits 1 and 0;
    //   bits 5 down to 2 are the factory test pins;
    //   bit 1 is the test mode pin;
    //   bit 0 is the acknowledge tolerance pin.
    // A slip in this map moves every mirrored field, so change both ends together.
    // Raw pin vector; the unmirrored tolerance pin enters it as bit 0.
    assign pin_raw = {byte_swap_pin, word_width_pin, operating_mode_pin, hub_enable_pin,
        ext_hub_write_pin, ext_hub_read_pin, code_bypass_pin, diagnostic_pin,
        tx_enable_polarity_pin, time_prescale_b1, time_prescale_b0, warn_prescale_b1,
        warn_prescale_b0, factory_test_pins, test_mode_pin, ack_tolerance_pin};

    // Shift pins through three flip-flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Accept each bit once stages two and three agree.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_q <= '1;
        end else begin
            for (int i = 0; i < NPIN; i++) begin
                if (sync2[i] == sync3[i]) begin
                    pin_q[i] <= sync3[i];
                end
            end
        end
    end

    logic test_active;
    logic hub_on;
    logic ack_tol;
    logic [6:0] upper_pins;
    logic [1:0] bus_pins;
    logic [5:0] lower_pins;
    reg16_t pin_word;

    // Test pins are active low; any low shows test mode.
    assign test_active = (pin_q[5:2] != 4'hf) || !pin_q[1];
    // Hub enable pin is active low, so a low level turns the hub on.
    assign hub_on = !pin_q[15];
    // The tolerance pin is synchronised like the others but never mirrored.
    assign ack_tol = pin_q[0];

    // Swap down to code bypass, in pin order.
    assign upper_pins = pin_q[18:12];
    // Swap and width again, so any bus setup finds them in the low byte.
    assign bus_pins = pin_q[18:17];
    // Diagnostic, polarity and the two low bits of both prescalers.
    assign lower_pins = pin_q[11:6];
    // Pin word layout.
    assign pin_word = {upper_pins, test_active, bus_pins, lower_pins};

    ////////////////////////////////////////////////////////////////////////////
    // Error cause fields.
    cause_t reconfig_cause;
    logic [3:0] line_code_fix_info;
    cause_t rx_error_cause;
    source_id_t failing_source_id;
    logic reconfig_ok;
    logic [1:0] multi_cnt;
    cause_t rx_code_eff;

    // With tolerance low only the noise cause reconfigures.
    assign reconfig_ok = ack_tol || (reconfig_code == `RECONFIG_NOISE);
    assign multi_cnt = 2'(rx_err_length) + 2'(rx_err_fixstop) + 2'(rx_err_page);

    // Pick the receive cause code, combining concurrent ones.
    always_comb begin
        rx_code_eff = rx_error_code;
        if (multi_cnt >= 2'd2) begin
            rx_code_eff = `RX_CAUSE_MULTI;
        end else if (rx_err_length) begin
            rx_code_eff = `RX_CAUSE_LENGTH;
        end else if (rx_err_fixstop) begin
            rx_code_eff = `RX_CAUSE_FIXSTOP;
        end else if (rx_err_page) begin
            rx_code_eff = `RX_CAUSE_PAGE;
        end
    end

    // Reconfiguration cause; a new event wins over a clear.
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            reconfig_cause <= '0;
        end else if (reconfig_event && reconfig_ok) begin
            reconfig_cause <= reconfig_code;
        end else if (clear_flags_cmd) begin
            reconfig_cause <= '0;
        end
    end

    // Line-code correction info with port bit held 0 while hub off.
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            line_code_fix_info <= '0;
        end else if (line_fix_event) begin
            line_code_fix_info <= {line_fix_port2 && hub_on, line_fix_code};
        end else if (line_fix_flag_clear) begin
            line_code_fix_info <= '0;
        end
    end

    // Receive error cause and failing source.
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            rx_error_cause <= '0;
            failing_source_id <= '0;
        end else if (rx_error_event || (|multi_cnt)) begin
            rx_error_cause <= rx_code_eff;
            failing_source_id <= rx_error_sid;
        end else if (rx_error_flag_clear) begin
            rx_error_cause <= '0;
            failing_source_id <= '0;
        end
    end

    reg16_t err_word;
    // Error register layout, bit 15 zero.
    assign err_word = {1'b0, reconfig_cause, line_code_fix_info, rx_error_cause,
        failing_source_id};

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status: sticky, cleared by read, set wins over clear.
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [2:0] irq_events;
    logic status_read;

    // Events that raise the status bits; a refused reconfiguration raises nothing.
    // The length, stop and page flags each count as a receive error by themselves.
    assign irq_events = {rx_error_event || (|multi_cnt), line_fix_event,
        reconfig_event && reconfig_ok};

    // Sticky status bits. A read of the status word clears them, but an event
    // in the same cycle as that read survives, so no event is ever lost.
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            irq_status <= `IRQ_RESET;
        end else if (status_read) begin
            irq_status <= irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    // The interrupt level is registered so the pin comes straight from a flip-flop.
    // It therefore follows the status and mask one cycle late.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel: address and data in either order.
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_mapped;
    logic wr_to_mask;

    // Decode the held write address. Every register answers OKAY, but only the
    // mask takes data; the status words stay read-only.
    always_comb begin
        wr_mapped = 1'b0;
        wr_to_mask = 1'b0;
        unique case (aw_addr[7:2])
            `IDX_SETUP_PIN_LEVELS: begin
                wr_mapped = 1'b1;
            end
            `IDX_ERROR_CAUSE_INFO: begin
                wr_mapped = 1'b1;
            end
            6'(`OFF_IRQ_STATUS >> 2): begin
                wr_mapped = 1'b1;
            end
            6'(`OFF_IRQ_MASK >> 2): begin
                wr_mapped = 1'b1;
                wr_to_mask = w_strb[0];
            end
            default: begin
                wr_mapped = 1'b0;
            end
        endcase
    end

    // Address and data are taken in either order; the response waits for both.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bresp <= wr_mapped ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Only the mask is writable; status registers ignore writes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= '0;
        end else if (aw_held && w_held && !s_axi_bvalid && wr_to_mask) begin
            irq_mask <= w_data[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel: one cycle from address to data.
    // A status read clears at the very edge that captures the old bits, so
    // the word handed to software is exactly what the clear removes.
    assign status_read = s_axi_arvalid && s_axi_arready &&
        s_axi_araddr[7:2] == 6'(`OFF_IRQ_STATUS >> 2);

    // Read data is captured at the address handshake and held until rready.
    // Unmapped words answer SLVERR with zero data.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                unique case (s_axi_araddr[7:2])
                    `IDX_SETUP_PIN_LEVELS: s_axi_rdata <= {16'h0000, pin_word};
                    `IDX_ERROR_CAUSE_INFO: s_axi_rdata <= {16'h0000, err_word};
                    6'(`OFF_IRQ_STATUS >> 2): s_axi_rdata <= {29'h0, irq_status};
                    6'(`OFF_IRQ_MASK >> 2): s_axi_rdata <= {29'h0, irq_mask};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : pin_and_error_status_regs

// file: testbench/status_regs_monitor.sv
// Purpose: Port checks for the pin and error status bank.
// Assumes: One clock; aresetn is synchronous and active low.
// Notes: Bound to the bank at the foot of this file.
module status_regs_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rd_addr;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Keeps the address of the read under way.
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr <= s_axi_araddr;
        end
    end
    ////////////////////////////////////////
    // Handshake, layout and reset checks.
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_cause: assert property ($rose(s_axi_rvalid)
        |-> $past(s_axi_arvalid) && $past(s_axi_arready))
        else $error("read data without request");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper half not zero");
    a_reserved_zero: assert property (s_axi_rvalid && rd_addr == 8'he8
        |-> !s_axi_rdata[15])
        else $error("reserved bit set");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
        !(s_axi_araddr[7:2] inside {6'h10, 6'h11, 6'h34, 6'h3a})
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read accepted");
    a_reset_quiet: assert property ($rose(aresetn) |-> !irq && !s_axi_rvalid && !s_axi_bvalid)
        else $error("outputs busy after reset");
    c_read_ok: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    c_irq: cover property ($rose(irq));
endmodule : status_regs_monitor

bind pin_and_error_status_regs status_regs_monitor u_mon (.*);

// file: testbench/test_pin_and_error_status_regs.sv
// Purpose: Self-checking bench for the pin and error status bank.
// Assumes: 50 MHz aclk; responses are noted in a queue and compared on arrival.
// Notes: Pin levels and source codes come from an LFSR.
module test_pin_and_error_status_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import pin_error_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [3:0] s_axi_wstrb, factory_test_pins;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic byte_swap_pin, word_width_pin, operating_mode_pin, hub_enable_pin, ext_hub_write_pin;
    logic ext_hub_read_pin, code_bypass_pin, diagnostic_pin, tx_enable_polarity_pin;
    logic time_prescale_b1, time_prescale_b0, warn_prescale_b1, warn_prescale_b0, test_mode_pin;
    logic ack_tolerance_pin, soft_reset, clear_flags_cmd, reconfig_event, line_fix_event;
    logic line_fix_port2, line_fix_flag_clear, rx_error_event, rx_err_length, rx_err_fixstop;
    logic rx_err_page, rx_error_flag_clear;
    logic [9:0] strb;
    logic [17:0] pin_v;
    cause_t reconfig_code, line_fix_code, rx_error_code;
    source_id_t rx_error_sid;
    logic [33:0] exp_q[$];
    int bad_count = 0, n_compared = 0;
    localparam logic [9:0] e_soft = 10'h200, e_clrf = 10'h100, e_rcf = 10'h080, e_fix = 10'h040;
    localparam logic [9:0] e_fixclr = 10'h020, e_rxe = 10'h010, e_len = 10'h008, e_page = 10'h002;
    localparam logic [9:0] e_rxclr = 10'h001, e_fstop = 10'h004;

    // Strobes and pin levels fan out from two vectors.
    assign {soft_reset, clear_flags_cmd, reconfig_event, line_fix_event, line_fix_flag_clear,
        rx_error_event, rx_err_length, rx_err_fixstop, rx_err_page, rx_error_flag_clear} = strb;
    assign {byte_swap_pin, word_width_pin, operating_mode_pin, hub_enable_pin, ext_hub_write_pin,
        ext_hub_read_pin, code_bypass_pin, diagnostic_pin, tx_enable_polarity_pin,
        time_prescale_b1, time_prescale_b0, warn_prescale_b1, warn_prescale_b0,
        factory_test_pins, test_mode_pin} = pin_v;

    pin_and_error_status_regs dut (.*);

    // Clock at 20 ns.
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [33:0] s, input logic [33:0] e);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, s, e);
        end
    endtask : check

    // Pulses event strobes for one cycle with a cause and a source.
    task automatic fire(input logic [9:0] s, input logic [2:0] c, input logic [4:0] id);
        @(posedge aclk);
        strb <= s;
        {reconfig_code, line_fix_code, rx_error_code, rx_error_sid} <= {c, c, c, id};
        @(posedge aclk);
        strb <= 10'h0;
    endtask : fire

    task automatic wt(ref logic s);
        repeat (50) begin
            @(posedge aclk);
            if (s === 1'b1) return;
        end
        bad_count++;
    endtask : wt

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        wt(s_axi_arready);
        s_axi_arvalid <= 1'b0;
        wt(s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd

    // Address and data are released separately as each is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        exp_q.push_back({e, 32'h0});
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        repeat (50) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                s_axi_bready <= 1'b0;
                return;
            end
        end
        bad_count++;
    endtask : wr

    // Compares each response handed over with the oldest note.
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, exp_q.pop_front());
    end

    task automatic end_sim;
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // Watchdog well beyond the expected run.
    initial begin
        #400000;
        bad_count++;
        end_sim();
    end

    ////////////////////////////////////////
    // Main sequence.
    initial begin
        {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready,
            s_axi_araddr, s_axi_arvalid, s_axi_rready, ack_tolerance_pin, line_fix_port2,
            reconfig_code, line_fix_code, rx_error_code, rx_error_sid, strb, pin_v} = '0;
        s_axi_wstrb = 4'hf;
        seed = 32'hb48612f7;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        fire(e_rxe, 3'h1, 5'h3);
        repeat (4) @(posedge aclk);
        check(34'(irq), 34'h0);
        wr(8'h44, 32'h4, 2'h0);
        repeat (3) @(posedge aclk);
        check(34'(irq), 34'h1);
        rd(8'h40, 34'h4);
        repeat (3) @(posedge aclk);
        check(34'(irq), 34'h0);
        fire(e_rxclr, 3'h0, 5'h0);
        rd(8'he8, 34'h0);
        $display("irq test done");
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            pin_v <= (i == 0) ? (seed[17:0] | 18'h1f) : seed[17:0];
            repeat (8) @(posedge aclk);
            rd(8'hd0, {18'h0, pin_v[17:11], ~&pin_v[4:0], pin_v[17:16],
                pin_v[10:5]});
        end
        $display("pin test done");
        fire(e_rcf, 3'h2, 5'h0);
        rd(8'he8, 34'h0);
        ack_tolerance_pin <= 1'b1;
        repeat (8) @(posedge aclk);
        for (int i = 0; i < 6; i++) begin
            fire(e_rcf, i[2:0], 5'h0);
            rd(8'he8, {19'h0, i[2:0], 12'h0});
        end
        fire(e_clrf, 3'h0, 5'h0);
        rd(8'he8, 34'h0);
        $display("reconfig test done");
        pin_v[14] <= 1'b0;
        repeat (8) @(posedge aclk);
        for (int i = 0; i < 16; i++) begin
            line_fix_port2 <= i[3];
            fire(e_fix, i[2:0], 5'h0);
            rd(8'he8, {22'h0, i[3:0], 8'h0});
        end
        pin_v[14] <= 1'b1;
        repeat (8) @(posedge aclk);
        fire(e_fix, 3'h6, 5'h0);
        rd(8'he8, 34'h600);
        fire(e_fixclr, 3'h0, 5'h0);
        rd(8'he8, 34'h0);
        $display("line fix test done");
        for (int i = 0; i < 7; i++) begin
            seed = lfsr(seed);
            fire(e_rxe, i[2:0], seed[4:0]);
            rd(8'he8, {26'h0, i[2:0], seed[4:0]});
        end
        fire(e_rxe | e_len | e_page, 3'h1, 5'h1f);
        rd(8'he8, 34'hff);
        fire(e_len, 3'h0, 5'h07);
        rd(8'he8, 34'h67);
        fire(e_fstop, 3'h0, 5'h02);
        rd(8'he8, 34'ha2);
        fire(e_page, 3'h0, 5'h04);
        rd(8'he8, 34'hc4);
        fire(e_len | e_fstop, 3'h0, 5'h06);
        rd(8'he8, 34'he6);
        fire(e_rxclr, 3'h0, 5'h0);
        rd(8'he8, 34'h0);
        $display("rx error test done");
        fire(e_rcf | e_rxe, 3'h3, 5'h05);
        rd(8'he8, 34'h3065);
        fire(e_soft, 3'h0, 5'h0);
        rd(8'he8, 34'h0);
        fire(e_rcf, 3'h4, 5'h0);
        wr(8'he8, 32'hffffffff, 2'h0);
        rd(8'he8, 34'h4000);
        rd(8'h50, {2'h2, 32'h0});
        wr(8'h50, 32'h1, 2'h2);
        $display("access test done");
        end_sim();
    end
endmodule : test_pin_and_error_status_regs
